/* bench/hv_cfg_monitor.sv */
// Checker for the config register ports, bound into the design.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module hv_cfg_monitor
	import hv_cfg_pkg::*;
#(parameter int LATENCY_CYC = 4) (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        cmd_wr,
	input wire logic [7:0]  cmd_wdata,
	input wire logic        irq_src_en,
	input wire logic [2:0]  hv_command_port,
	input wire logic [11:0] hv_data_port,
	input wire logic [7:0]  hv_circuit_config_zero,
	input wire hv_ctrl_t    hv_ctrl,
	input wire logic        supply_monitor_irq,
	input wire logic        low_voltage_flag
);
	// Busy reads high for LATENCY_CYC samples, so the last high one is one earlier
	localparam int BUSY_LAST = LATENCY_CYC - 1;
	wire logic       busy = hv_command_port[0];
	wire logic [7:0] cfg = hv_circuit_config_zero;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Handshake timing and atomic update
	chk_busy_start: assert property (cmd_wr && !busy && cmd_wdata inside {8'h00, 8'h08} |=> busy)
		else $error("busy not raised");
	chk_busy_span: assert property ($rose(busy) |-> ##BUSY_LAST busy ##1 !busy)
		else $error("busy length wrong");
	chk_cfg_atomic: assert property (!$fell(busy) |-> $stable(cfg))
		else $error("config changed outside completion");
	chk_data_echo: assert property ($fell(busy) |-> hv_data_port == {hv_command_port[2] ? 4'h8 : 4'h0, cfg})
		else $error("data port wrong");
	// Decoded controls follow the register a cycle later
	chk_decode_main: assert property (!$past(sys_rst) |-> hv_ctrl.osc_en == $past(cfg[6])
		&& hv_ctrl.bit_serial_mode == $past(cfg[5]) && hv_ctrl.bus_pullup_en != $past(cfg[5])
		&& hv_ctrl.xcvr_mode == $past(cfg[1:0])) else $error("decode wrong");
	chk_decode_more: assert property (!$past(sys_rst) |-> hv_ctrl.therm_shutdown_en != $past(cfg[7])
		&& hv_ctrl.xcvr_driver_en == ($past(cfg[1:0]) == 2'h2)) else $error("decode wrong");
	chk_irq_cause: assert property (supply_monitor_irq |-> $past(cfg[3]) && $past(irq_src_en))
		else $error("interrupt without cause");
	chk_flag_sticky: assert property (low_voltage_flag |=> low_voltage_flag)
		else $error("flag dropped");
	cov_write: cover property ($fell(busy) && hv_command_port[2]);
	cov_read: cover property ($fell(busy) && hv_command_port[1]);
	cov_irq: cover property ($rose(supply_monitor_irq));
endmodule : hv_cfg_monitor
bind hv_config_zero_register hv_cfg_monitor #(.LATENCY_CYC(LATENCY_CYC)) u_mon (.*);
`default_nettype wire

/* bench/hv_sw_model.sv */
// Software model driving the command and data ports.
// Assumes each call starts just after a rising clk edge.
`timescale 1ns/1ps
`default_nettype none
module hv_sw_model (
	input  wire logic       clk,
	input  wire logic [2:0] hv_command_port,
	output var  logic       cmd_wr,
	output var  logic [7:0] cmd_wdata,
	output var  logic       dat_wr,
	output var  logic [7:0] dat_wdata
);
	// Idle strobes low
	initial begin
		cmd_wr = 1'h0;
		dat_wr = 1'h0;
		cmd_wdata = 8'h55;
		dat_wdata = 8'haa;
	end
	// One command, a write strobing its data with bit 0 cleared in the same cycle, then wait for completion
	task automatic op(input logic [7:0] c, input logic [7:0] d, output logic [2:0] st);
		repeat (20) if (hv_command_port[0]) @(posedge clk) #1;
		cmd_wr = 1'h1;
		cmd_wdata = c;
		dat_wr = c == 8'h08;
		dat_wdata = {d[7:1], 1'h0};
		@(posedge clk) #1;
		cmd_wr = 1'h0;
		dat_wr = 1'h0;
		cmd_wdata = ~c;
		dat_wdata = ~d;
		repeat (20) if (hv_command_port[0]) @(posedge clk) #1;
		st = hv_command_port;
	endtask : op
endmodule : hv_sw_model
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the config register.
// Assumes design, checker and software model compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb
	import hv_cfg_pkg::*;
;
	logic        clk = 1'h0, sys_rst = 1'h1, clk_en = 1'h1, cmd_wr, dat_wr, irq_src_en = 1'h0;
	logic        thermal_event_pin = 1'h0, supply_low_pin = 1'h0, core_supply_low_pin = 1'h0;
	logic [7:0]  cmd_wdata, dat_wdata, hv_circuit_config_zero;
	logic [2:0]  hv_command_port, st;
	logic [11:0] hv_data_port;
	hv_ctrl_t    hv_ctrl;
	logic        diag_driver_off, supply_monitor_irq, low_voltage_flag;
	int          bad_count = 0, check_count = 0;
	hv_config_zero_register #(.LATENCY_CYC(4)) u_dut (.*);
	hv_sw_model u_sw (.*);
	always #2 clk = ~clk;
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	// Reset clears register and flag, decode shows the zero config
	task automatic t_reset;
		sys_rst = 1'h1;
		repeat (20) @(posedge clk) #1;
		sys_rst = 1'h0;
		repeat (2) @(posedge clk) #1;
		chk({hv_circuit_config_zero, low_voltage_flag}, 9'h0);
		chk(hv_ctrl, 10'h280);
	endtask : t_reset
	// Write and read back patterns, both mode codes
	task automatic t_write_read;
		logic [7:0] v [4] = '{8'hfe, 8'h56, 8'ha8, 8'h00};
		foreach (v[i]) begin
			u_sw.op(8'h08, v[i], st);
			chk({st, hv_circuit_config_zero}, {3'h4, v[i]});
			chk(hv_data_port, {4'h8, v[i]});
			u_sw.op(8'h00, 8'h00, st);
			chk({st, hv_data_port}, {3'h2, 4'h0, v[i]});
			chk(hv_ctrl, {~v[i][7], v[i][6], ~v[i][5], v[i][5:2], v[i][1:0], v[i][1:0] == 2'h2});
		end
	endtask : t_write_read
	// Interrupt, thermal shutdown and its disable, sticky flag
	task automatic t_pins;
		u_sw.op(8'h08, 8'h1c, st);
		{irq_src_en, supply_low_pin, core_supply_low_pin, thermal_event_pin} = 4'hf;
		repeat (4) @(posedge clk) #1;
		chk({supply_monitor_irq, low_voltage_flag, diag_driver_off, hv_ctrl.wake_pin_drive}, 4'he);
		{irq_src_en, core_supply_low_pin} = 2'h0;
		u_sw.op(8'h08, 8'h9c, st);
		repeat (4) @(posedge clk) #1;
		chk({supply_monitor_irq, low_voltage_flag, diag_driver_off, hv_ctrl.wake_pin_drive}, 4'h5);
		thermal_event_pin = 1'h0;
	endtask : t_pins
	initial begin
		t_reset;
		t_write_read;
		t_pins;
		t_reset;
		report_and_stop;
	end
	// Watchdog well beyond the expected hundred or so cycles
	initial begin
		#20000;
		bad_count++;
		report_and_stop;
	end
endmodule : tb
`default_nettype wire

/* core/hv_cfg_pkg.sv */
// Types shared by the high-voltage configuration block.
// Assumes hv_cfg_regs.svh is on the include path.
`include "hv_cfg_regs.svh"

package hv_cfg_pkg;

	// Transceiver modes of bits 1..0
	typedef enum logic [1:0] {
		MODE_OFF   = 2'b00,
		MODE_RSVD1 = 2'b01,
		MODE_ON    = 2'b10,
		MODE_RSVD3 = 2'b11
	} xcvr_mode_t;

	// Decoded controls to the high-voltage circuits
	typedef struct packed {
		logic       therm_shutdown_en;
		logic       osc_en;
		logic       bus_pullup_en;
		logic       bit_serial_mode;
		logic       wake_pin_drive;
		logic       supply_monitor_en;
		logic       low_voltage_flag_en;
		xcvr_mode_t xcvr_mode;
		logic       xcvr_driver_en;
	} hv_ctrl_t;

	// Command port status read view
	typedef struct packed {
		logic tx_ok;
		logic rx_ok;
		logic busy;
	} cmd_status_t;

	// Latency counter state
	typedef struct packed {
		logic        run;
		logic [11:0] cnt;
	} lat_state_t;

	// Controller states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_WRITE = 2'b01,
		ST_READ  = 2'b10
	} cmd_state_t;

	// State of the main module, less its synchronisers
	typedef struct packed {
		cmd_state_t  st;
		logic [7:0]  cfg;
		logic [7:0]  pend;
		logic [11:0] dat;
		cmd_status_t stat;
		hv_ctrl_t    ctrl;
		logic        therm_off;
		logic        supply_irq;
		logic        lvf_seen;
	} hv_state_t;

endpackage : hv_cfg_pkg

/* core/hv_cfg_regs.svh */
// Command codes, field positions, reset values and timing counts of the
// high-voltage configuration block. Included by the package and modules.
`ifndef HV_CFG_REGS_SVH
`define HV_CFG_REGS_SVH

// Command codes written to the command port
`define HV_CMD_READ_CFG0   8'h00
`define HV_CMD_WRITE_CFG0  8'h08

// Field positions of the configuration register
`define HV_CFG0_THERM_DIS  7
`define HV_CFG0_OSC_EN     6
`define HV_CFG0_BSD_EN     5
`define HV_CFG0_WAKE_HI    4
`define HV_CFG0_PSM_EN     3
`define HV_CFG0_LVF_EN     2
`define HV_CFG0_MODE_HI    1
`define HV_CFG0_MODE_LO    0

// Reset value and mode codes
`define HV_CFG0_RESET      8'h00
`define HV_MODE_OFF        2'h0
`define HV_MODE_ON         2'h2

// Interface latency of the high-voltage link
`define HV_LATENCY_NS      10000
`define HV_CLK_PERIOD_NS   4
`define HV_LATENCY_CYC     ((`HV_LATENCY_NS + `HV_CLK_PERIOD_NS - 1) / `HV_CLK_PERIOD_NS)

`endif

/* core/hv_config_zero_register.sv */
// High-voltage configuration register zero behind the indirect command port.
// Assumes software drives command/data writes as single-cycle strobes on clk,
// and that the analog status pins are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "hv_cfg_regs.svh"

module hv_config_zero_register
	import hv_cfg_pkg::*;
#(
	parameter int LATENCY_CYC = `HV_LATENCY_CYC
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	input  wire logic        cmd_wr,
	input  wire logic [7:0]  cmd_wdata,
	input  wire logic        dat_wr,
	input  wire logic [7:0]  dat_wdata,
	input  wire logic        thermal_event_pin,
	input  wire logic        supply_low_pin,
	input  wire logic        core_supply_low_pin,
	input  wire logic        irq_src_en,
	output var  logic [2:0]  hv_command_port,
	output var  logic [11:0] hv_data_port,
	output var  logic [7:0]  hv_circuit_config_zero,
	output var  hv_ctrl_t    hv_ctrl,
	output var  logic        diag_driver_off,
	output var  logic        supply_monitor_irq,
	output var  logic        low_voltage_flag
);

	initial begin
		if (LATENCY_CYC < 1 || LATENCY_CYC > 4095) $error("LATENCY_CYC out of range");
	end

	hv_state_t s_q, s_d;
	logic [2:0] sync1_q, sync2_q;
	logic       lat_start;
	logic       lat_done;

	// Decode a configuration byte into circuit controls
	function automatic hv_ctrl_t decode_cfg(input logic [7:0] c);
		hv_ctrl_t r;
		r.therm_shutdown_en   = ~c[`HV_CFG0_THERM_DIS];
		r.osc_en              = c[`HV_CFG0_OSC_EN];
		r.bus_pullup_en       = ~c[`HV_CFG0_BSD_EN];
		r.bit_serial_mode     = c[`HV_CFG0_BSD_EN];
		r.wake_pin_drive      = c[`HV_CFG0_WAKE_HI];
		r.supply_monitor_en   = c[`HV_CFG0_PSM_EN];
		r.low_voltage_flag_en = c[`HV_CFG0_LVF_EN];
		r.xcvr_mode           = xcvr_mode_t'(c[`HV_CFG0_MODE_HI:`HV_CFG0_MODE_LO]);
		r.xcvr_driver_en      = (c[`HV_CFG0_MODE_HI:`HV_CFG0_MODE_LO] == `HV_MODE_ON);
		return r;
	endfunction : decode_cfg

	// Two-stage synchronisers for the analog status pins
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
		end else if (clk_en) begin
			sync1_q <= {core_supply_low_pin, supply_low_pin, thermal_event_pin};
			sync2_q <= sync1_q;
		end
	end

	// Link latency for each command
	hv_latency_timer #(
		.CYCLES (LATENCY_CYC)
	) u_lat (
		.clk     (clk),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.start   (lat_start),
		.done    (lat_done)
	);

	// Command flow in brief:
	// Idle, command strobe seen, busy raised next cycle.
	// Write takes data strobed in the same cycle,
	// otherwise the last byte held in the data port.
	// The pending byte waits in its own flops.
	// The live register never sees a half-written byte.
	// Latency timer counts the link delay to the far die.
	// Busy stays high while the timer runs.
	// Busy reads high for LATENCY_CYC cycles in all.
	// Register, status and data change in one cycle.
	// That cycle is the one in which busy falls.
	// Read copies the live register into the data port.
	// Read tag bits show zero, write tag bits show eight.
	// Status bits are only meaningful with busy low.
	//
	// Refused traffic:
	// Command strobes while busy are dropped.
	// Data strobes while busy are dropped too.
	// Dropping them keeps the pending byte stable.
	// Unknown codes clear the status, no busy.
	// Reserved mode codes are stored as written.
	// Driver enable only for the normal mode code.
	// Reserved codes therefore leave the driver off.
	//
	// Circuit controls:
	// Decoded one cycle after the register.
	// The extra cycle keeps outputs on flops.
	// Wake drive is forced low during thermal shutdown.
	// Thermal shutdown latches until released.
	// Release by clearing wake drive or disabling shutdown.
	// Without the latch the pin would toggle with the event.
	//
	// Status pins from the analog side:
	// All are asynchronous, two flops each.
	// Nothing reads the first flop but the second.
	// Outputs follow a pin change in three cycles.
	// Supply interrupt is a plain level, not latched.
	// Interrupt source enable gates it directly.
	// Low-voltage flag is sticky until reset.
	// It sets only while its function is enabled.
	//
	// Clock enable low freezes every flop here.
	// The timer and synchronisers freeze with it.
	// A frozen command resumes where it stopped.

	// Command interpreter, register and circuit controls
	always_comb begin
		s_d       = s_q;
		lat_start = 1'b0;
		if (dat_wr && s_q.st == ST_IDLE) begin
			s_d.dat = {4'h0, dat_wdata};
		end
		case (s_q.st)
			ST_IDLE: begin
				if (cmd_wr) begin
					if (cmd_wdata == `HV_CMD_WRITE_CFG0) begin
						s_d.st    = ST_WRITE;
						s_d.pend  = dat_wr ? dat_wdata : s_q.dat[7:0];
						s_d.stat  = 3'b001;
						lat_start = 1'b1;
					end else if (cmd_wdata == `HV_CMD_READ_CFG0) begin
						s_d.st    = ST_READ;
						s_d.stat  = 3'b001;
						lat_start = 1'b1;
					end else begin
						s_d.stat  = 3'b000;                               // Unknown command fails
					end
				end
			end
			ST_WRITE: begin
				if (lat_done) begin
					s_d.cfg  = s_q.pend;
					s_d.dat  = {4'h8, s_q.pend};
					s_d.stat = 3'b100;
					s_d.st   = ST_IDLE;
				end
			end
			ST_READ: begin
				if (lat_done) begin
					s_d.dat  = {4'h0, s_q.cfg};
					s_d.stat = 3'b010;
					s_d.st   = ST_IDLE;
				end
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase
		s_d.ctrl       = decode_cfg(s_q.cfg);
		// Thermal shutdown latches off until disabled or bit 4 cleared
		s_d.therm_off  = s_q.cfg[`HV_CFG0_WAKE_HI] && ~s_q.cfg[`HV_CFG0_THERM_DIS]
			&& (s_q.therm_off || sync2_q[0]);
		s_d.supply_irq = s_q.cfg[`HV_CFG0_PSM_EN] && irq_src_en && sync2_q[1];
		// Flag is sticky; set only while the function is enabled
		s_d.lvf_seen   = s_q.lvf_seen || (s_q.cfg[`HV_CFG0_LVF_EN] && sync2_q[2]);
		if (s_d.therm_off) begin
			s_d.ctrl.wake_pin_drive = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.cfg <= `HV_CFG0_RESET;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state flops
	assign hv_command_port        = s_q.stat;
	assign hv_data_port           = s_q.dat;
	assign hv_circuit_config_zero = s_q.cfg;
	assign hv_ctrl                = s_q.ctrl;
	assign diag_driver_off        = s_q.therm_off;
	assign supply_monitor_irq     = s_q.supply_irq;
	assign low_voltage_flag       = s_q.lvf_seen;

endmodule : hv_config_zero_register

`default_nettype wire

/* core/hv_latency_timer.sv */
// Counts the high-voltage link latency after a start pulse.
// Assumes a start only while idle; same clock and reset as its parent.
`timescale 1ns/1ps
`default_nettype none
`include "hv_cfg_regs.svh"

module hv_latency_timer
	import hv_cfg_pkg::*;
#(
	parameter int CYCLES = `HV_LATENCY_CYC
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic clk_en,
	input  wire logic start,
	output var  logic done
);

	initial begin
		if (CYCLES < 1 || CYCLES > 4095) $error("CYCLES out of range");
	end

	lat_state_t s_q, s_d;

	// Count down, pulse done at the end
	always_comb begin
		s_d  = s_q;
		done = 1'b0;
		if (start) begin
			s_d.run = 1'b1;
			s_d.cnt = 12'(CYCLES - 1);
		end else if (s_q.run) begin
			if (s_q.cnt == 12'h000) begin
				s_d.run = 1'b0;
				done    = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt - 12'h001;
			end
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q <= '0;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

endmodule : hv_latency_timer

`default_nettype wire
